// ===== common/pmm_pkg.sv
package pmm_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_GAINS  = 8'h08;
  localparam logic [7:0] OFS_ADC    = 8'h0c;
  localparam logic [7:0] OFS_SPEED  = 8'h10;

  // control and status bits and reset values
  localparam int         CTRL_CLOSED = 0;
  localparam int         CTRL_BRAKE  = 1;
  localparam int         CTRL_AUTOCLR = 2;
  localparam int         STAT_OVF    = 3;
  localparam logic [2:0] CTRL_RST    = 3'h4;
  localparam logic [31:0] GAINS_RST  = 32'h10000408; // sp_gain kd ki kp

  // sine table geometry, index has 8 fraction bits
  localparam logic [7:0]  STEPS_PER_REV = 8'hc0;
  localparam logic [7:0]  HALF_REV      = 8'h60;
  localparam logic [7:0]  PHASE_V       = 8'h40;
  localparam logic [7:0]  PHASE_W       = 8'h80;
  localparam logic [15:0] IDX_WRAP      = 16'hc000;
  localparam logic [15:0] INC_NUM       = 16'h2000; // 32 steps per sector
  localparam logic [7:0]  MID           = 8'h80;
  localparam logic [17:0] SINE_SCALE    = 18'h00039;

  // bus answers and converter channels
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic       CH_SPEED    = 1'b0;

  typedef enum logic [3:0] {
    ST_WAIT  = 4'h1,
    ST_BLOCK = 4'h2,
    ST_SINE  = 4'h4,
    ST_STOP  = 4'h8
  } drive_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  // bit 0 phase u, bit 1 phase v, bit 2 phase w
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } gate_t;

  typedef struct packed {
    drive_state_t st;
    logic [1:0]   prime;
    logic [2:0]   hall_s1;
    logic [2:0]   hall_s2;
    logic [2:0]   hall_prev;
    logic         dir_s1;
    logic         dir_s2;
    logic         dir_prev;
    logic [7:0]   div_cnt;
    logic [7:0]   cnt;
    logic         cnt_down;
    logic [15:0]  ticks;
    logic         halted;
    logic         locked;
    logic [3:0]   match;
    logic         actual_rev;
    logic         reverse;
    logic         tacho;
    logic [15:0]  idx;
    logic [15:0]  inc;
    logic [7:0]   cmp_u;
    logic [7:0]   cmp_v;
    logic [7:0]   cmp_w;
    logic [7:0]   amp;
    logic [7:0]   duty;
    gate_t        gate;
    logic         ovf;
    logic         adc_busy;
    logic         adc_start;
    logic         adc_chan;
    logic [7:0]   speed_ref;
    logic [7:0]   current;
    logic [19:0]  integ;
    logic [16:0]  err_prev;
    logic [2:0]   ctrl;
    logic [31:0]  gains;
    logic         aw_have;
    logic         w_have;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    axi_rsp_t     rsp;
  } state_t;

endpackage : pmm_pkg

// ===== hw/pmm_drive_ctrl.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module pmm_drive_ctrl #(
  parameter logic [7:0]  PWM_DIV    = 8'h01,
  parameter logic [15:0] HALT_TICKS = 16'h0400,
  parameter logic [3:0]  LOCK_COUNT = 4'h2
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus
  input  pmm_pkg::axi_req_t axi_req,
  output pmm_pkg::axi_rsp_t axi_rsp,
  // hall sensors and direction pin
  input  wire logic [2:0]  hall_in,
  input  wire logic        dir_in,
  // gate drivers
  output pmm_pkg::gate_t    gate,
  // status pins
  output logic             reverse_out,
  output logic             tacho_out,
  // converter, same clock
  output logic             adc_start,
  output logic             adc_chan,
  input  wire logic        adc_done,
  input  wire logic [7:0]  adc_data
);
  import pmm_pkg::*;

  state_t r;
  state_t n;

  // sector of a hall code, 7 for an illegal code
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'h1: return 3'h0;
      3'h5: return 3'h1;
      3'h4: return 3'h2;
      3'h6: return 3'h3;
      3'h2: return 3'h4;
      3'h3: return 3'h5;
      default: return 3'h7;
    endcase
  endfunction : hall_sector

  function automatic logic [2:0] sector_step(input logic [2:0] s, input logic back);
    if (back) begin
      return (s == 3'h0) ? 3'h5 : s - 3'h1;
    end
    return (s == 3'h5) ? 3'h0 : s + 3'h1;
  endfunction : sector_step

  // forward pattern {hi, lo}; reverse swaps the halves
  function automatic gate_t block_mask(input logic [2:0] s, input logic rev);
    gate_t g;
    case (s)
      3'h0: g = '{hi: 3'h1, lo: 3'h2};
      3'h1: g = '{hi: 3'h1, lo: 3'h4};
      3'h2: g = '{hi: 3'h2, lo: 3'h4};
      3'h3: g = '{hi: 3'h2, lo: 3'h1};
      3'h4: g = '{hi: 3'h4, lo: 3'h1};
      3'h5: g = '{hi: 3'h4, lo: 3'h2};
      default: g = '{hi: 3'h0, lo: 3'h0};
    endcase
    if (rev) begin
      g = '{hi: g.lo, lo: g.hi};
    end
    return g;
  endfunction : block_mask

  function automatic logic [7:0] wrap_pos(input logic [8:0] p);
    return (p >= 9'(STEPS_PER_REV)) ? 8'(p - 9'(STEPS_PER_REV)) : p[7:0];
  endfunction : wrap_pos

  // parabolic sine, centred on MID and scaled by amp
  function automatic logic [7:0] phase_cmp(input logic [7:0] pos, input logic [7:0] amp);
    logic [7:0]  x;
    logic [17:0] y;
    logic [6:0]  m;
    logic [14:0] p;
    x = (pos >= HALF_REV) ? pos - HALF_REV : pos;
    y = (18'(x) * 18'(HALF_REV - x)) * SINE_SCALE;
    m = (y[17:10] > 8'h7f) ? 7'h7f : y[16:10];
    p = 15'(m) * 15'(amp);
    return (pos < HALF_REV) ? MID + 8'(p[14:8]) : MID - 8'(p[14:8]);
  endfunction : phase_cmp

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        o[8*i +: 8] = d[8*i +: 8];
      end
    end
    return o;
  endfunction : wmerge

  function automatic logic [7:0] clamp8(input logic signed [31:0] v);
    if (v < 0) begin
      return 8'h00;
    end
    return (v > 32'sd255) ? 8'hff : v[7:0];
  endfunction : clamp8

  logic               div_en;
  logic               tick_c;
  logic               ovf_c;
  logic               hall_evt;
  logic               dir_evt;
  logic               fwd_step;
  logic               rev_step;
  logic               match_c;
  logic               sw_clr;
  logic               wr_go;
  logic [2:0]         sec_c;
  logic [2:0]         sec_p;
  logic [7:0]         pos_u;
  logic [16:0]        isum;
  logic [15:0]        setp;
  logic signed [16:0] err;
  logic signed [31:0] pid_c;
  logic [31:0]        rd_data;
  logic [1:0]         rd_resp;
  gate_t              bm;

  // next state of the whole block
  always_comb begin
    n         = r;
    n.adc_start = 1'b0;
    sw_clr    = 1'b0;
    isum      = '0;
    pos_u     = r.idx[15:8];
    // synchronisers; first stage feeds only the second
    n.hall_s1 = hall_in;
    n.hall_s2 = r.hall_s1;
    n.dir_s1  = dir_in;
    n.dir_s2  = r.dir_s1;
    if (r.prime != 2'h3) begin
      n.prime     = r.prime + 2'h1;
      n.hall_prev = r.hall_s2;
      n.dir_prev  = r.dir_s2;
    end
    hall_evt = (r.prime == 2'h3) && (r.hall_s2 != r.hall_prev);
    dir_evt  = (r.prime == 2'h3) && (r.dir_s2 != r.dir_prev);

    // centre aligned timer, 510 steps per period
    div_en    = (r.div_cnt == PWM_DIV - 8'h01);
    n.div_cnt = div_en ? 8'h00 : r.div_cnt + 8'h01;
    tick_c    = div_en && r.cnt_down && (r.cnt == 8'h00);
    ovf_c     = div_en && !r.cnt_down && (r.cnt == 8'hff);
    if (div_en) begin
      if (r.cnt_down) begin
        n.cnt_down = (r.cnt != 8'h00);
        n.cnt      = (r.cnt == 8'h00) ? 8'h01 : r.cnt - 8'h01;
      end else begin
        n.cnt_down = (r.cnt == 8'hff);
        n.cnt      = (r.cnt == 8'hff) ? 8'hfe : r.cnt + 8'h01;
      end
    end

    // per period handler: halt check, index advance, compares
    if (tick_c) begin
      if (r.ticks != 16'hffff) begin
        n.ticks = r.ticks + 16'h0001;
      end
      if ((r.ticks >= HALT_TICKS) && !r.halted) begin
        n.halted  = 1'b1;
        n.locked  = 1'b0;
        n.reverse = 1'b1;
      end
      if (r.actual_rev) begin
        n.idx = (r.idx >= r.inc) ? r.idx - r.inc : r.idx + (IDX_WRAP - r.inc);
      end else begin
        isum  = {1'b0, r.idx} + {1'b0, r.inc};
        n.idx = (isum >= {1'b0, IDX_WRAP}) ? 16'(isum - {1'b0, IDX_WRAP}) : isum[15:0];
      end
      n.cmp_u = phase_cmp(pos_u, r.amp);
      n.cmp_v = phase_cmp(wrap_pos(9'(pos_u) + 9'(PHASE_V)), r.amp);
      n.cmp_w = phase_cmp(wrap_pos(9'(pos_u) + 9'(PHASE_W)), r.amp);
    end

    // hall edge handler; it wins over a halt in the same cycle
    sec_c    = hall_sector(r.hall_s2);
    sec_p    = hall_sector(r.hall_prev);
    fwd_step = (sec_p != 3'h7) && (sec_c == sector_step(sec_p, 1'b0));
    rev_step = (sec_p != 3'h7) && (sec_c == sector_step(sec_p, 1'b1));
    match_c  = r.dir_prev ? rev_step : fwd_step;
    if (hall_evt) begin
      n.hall_prev = r.hall_s2;
      n.halted    = 1'b0;
      n.tacho     = ~r.tacho;
      n.reverse   = !match_c;
      if (fwd_step || rev_step) begin
        n.actual_rev = rev_step;
      end
      n.match  = !match_c ? 4'h0 : (r.match == 4'hf) ? r.match : r.match + 4'h1;
      n.locked = match_c && (n.match >= LOCK_COUNT);
      if (sec_c != 3'h7) begin
        n.idx = {sec_c, 5'h00, 8'h00};
      end
      n.inc   = INC_NUM / ((r.ticks == 16'h0000) ? 16'h0001 : r.ticks);
      n.ticks = 16'h0000;
    end

    // drive sequencing
    case (r.st)
      ST_WAIT: begin
        if (r.locked) begin
          n.st = ST_SINE;
        end else if (r.halted) begin
          n.st = ST_BLOCK;
        end
      end
      ST_BLOCK: begin
        if (r.locked) begin
          n.st = ST_SINE;
        end
      end
      ST_SINE: begin
        if (r.halted) begin
          n.st = ST_BLOCK;
        end
      end
      ST_STOP: begin
        if (r.locked) begin
          n.st = ST_SINE;
        end else if (r.halted) begin
          n.st = ST_BLOCK;
        end
      end
      default: n.st = ST_WAIT;
    endcase

    // direction request overrides lock and halt of this cycle
    if (dir_evt) begin
      n.dir_prev = r.dir_s2;
      n.locked   = 1'b0;
      n.halted   = 1'b0;
      n.match    = 4'h0;
      n.st       = ST_STOP;
    end

    // gate outputs; dead time is left to the driver stage
    bm = block_mask(sec_p, r.dir_prev);
    case (r.st)
      ST_SINE: begin
        n.gate.hi = {r.cnt < r.cmp_w, r.cnt < r.cmp_v, r.cnt < r.cmp_u};
        n.gate.lo = ~n.gate.hi;
      end
      ST_BLOCK: begin
        n.gate.hi = bm.hi & {3{r.cnt < r.duty}};
        n.gate.lo = bm.lo & {3{r.cnt < r.duty}};
      end
      ST_STOP: begin
        n.gate.hi = 3'h0;
        n.gate.lo = r.ctrl[CTRL_BRAKE] ? 3'h7 : 3'h0;
      end
      default: begin
        n.gate.hi = 3'h0;
        n.gate.lo = 3'h0;
      end
    endcase

    // converter sequencing on timer overflow
    if (ovf_c && !r.ovf && !r.adc_busy) begin
      n.adc_start = 1'b1;
      n.adc_busy  = 1'b1;
    end
    setp  = 16'(adc_data) * 16'(r.gains[31:24]);
    err   = $signed({1'b0, setp}) - $signed({1'b0, r.inc});
    pid_c = (32'(err) * 32'($signed({1'b0, r.gains[7:0]}))
           + 32'($signed(r.integ)) * 32'($signed({1'b0, r.gains[15:8]}))
           + 32'(err - $signed(r.err_prev)) * 32'($signed({1'b0, r.gains[23:16]}))) >>> 8;
    if (adc_done) begin
      n.adc_busy = 1'b0;
      n.adc_chan = ~r.adc_chan;
      if (r.adc_chan == CH_SPEED) begin
        n.speed_ref = adc_data;
        n.duty      = adc_data;
        if (r.ctrl[CTRL_CLOSED]) begin
          n.amp      = clamp8(32'($signed({1'b0, adc_data})) + pid_c);
          n.integ    = r.integ + 20'(err);
          n.err_prev = err;
        end else begin
          n.amp = adc_data;
        end
      end else begin
        n.current = adc_data;
      end
    end

    // register writes, taken once address and data are both held
    if (axi_req.awvalid && r.rsp.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && r.rsp.wready) begin
      n.w_have = 1'b1;
      n.w_data = axi_req.wdata;
      n.w_strb = axi_req.wstrb;
    end
    if (r.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    wr_go = r.aw_have && r.w_have && !r.rsp.bvalid;
    if (wr_go) begin
      n.aw_have    = 1'b0;
      n.w_have     = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = RESP_OKAY;
      case (r.aw_addr)
        OFS_CTRL:   n.ctrl  = 3'(wmerge({29'h0, r.ctrl}, r.w_data, r.w_strb));
        OFS_STATUS: sw_clr  = r.w_strb[0] && r.w_data[STAT_OVF];
        OFS_GAINS:  n.gains = wmerge(r.gains, r.w_data, r.w_strb);
        OFS_ADC, OFS_SPEED: n.rsp.bresp = RESP_OKAY;
        default:    n.rsp.bresp = RESP_SLVERR;
      endcase
    end
    // overflow flag: a new overflow wins over any clear
    n.ovf = ovf_c || (r.ovf && !(sw_clr || (adc_done && r.ctrl[CTRL_AUTOCLR])));
    n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_have && !n.rsp.bvalid;

    // register reads
    rd_resp = RESP_OKAY;
    case (axi_req.araddr)
      OFS_CTRL:   rd_data = {29'h0, r.ctrl};
      OFS_STATUS: rd_data = {20'h0, 4'(r.st), 3'h0, r.actual_rev, r.ovf,
                             r.reverse, r.locked, r.halted};
      OFS_GAINS:  rd_data = r.gains;
      OFS_ADC:    rd_data = {8'h00, r.amp, r.current, r.speed_ref};
      OFS_SPEED:  rd_data = {16'h0000, r.inc};
      default: begin
        rd_data = 32'h0;
        rd_resp = RESP_SLVERR;
      end
    endcase
    if (r.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && r.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata  = rd_data;
      n.rsp.rresp  = rd_resp;
    end
    n.rsp.arready = !n.rsp.rvalid;
  end

  // one register for all state; reset loads constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r         <= '0;
      r.st      <= ST_WAIT;
      r.ctrl    <= CTRL_RST;
      r.gains   <= GAINS_RST;
      r.reverse <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign axi_rsp     = r.rsp;
  assign gate        = r.gate;
  assign reverse_out = r.reverse;
  assign tacho_out   = r.tacho;
  assign adc_start   = r.adc_start;
  assign adc_chan    = r.adc_chan;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  open_loop_amp_a: assert property (
    adc_done && r.adc_chan == CH_SPEED && !r.ctrl[CTRL_CLOSED] |=> r.amp == $past(adc_data))
    else $error("open loop amplitude differs from reference");
  closed_loop_amp_a: assert property (
    adc_done && r.adc_chan == CH_SPEED && r.ctrl[CTRL_CLOSED] && pid_c >= 0
    |=> r.amp >= $past(adc_data))
    else $error("closed loop amplitude below feed forward");
  compare_once_a: assert property (
    $changed(r.cmp_u) || $changed(r.cmp_v) |-> $past(tick_c))
    else $error("compare changed outside period tick");
  halt_unlock_a: assert property (
    $rose(r.halted) |-> !r.locked && r.reverse && $past(tick_c))
    else $error("halt set without tick or lock kept");
  hall_edge_a: assert property (
    hall_evt && !dir_evt |=> !r.halted && r.tacho != $past(r.tacho) && r.ticks == 16'h0)
    else $error("hall change not handled");
  dir_change_a: assert property (
    dir_evt |=> !r.locked && !r.halted && r.st == ST_STOP ##1 r.gate.hi == 3'h0)
    else $error("direction change not handled");
  wait_no_drive_a: assert property (
    r.st == ST_WAIT |=> r.gate.hi == 3'h0 && r.gate.lo == 3'h0)
    else $error("drive applied before lock or halt");
  sine_entry_a: assert property (
    r.st == ST_SINE && $past(r.st) != ST_SINE |-> $past(r.locked))
    else $error("sine drive entered without lock");
  start_gate_a: assert property (
    r.adc_start |-> $past(ovf_c) && !$past(r.ovf) ##1 !r.adc_start)
    else $error("conversion started without clear flag");
  chan_swap_a: assert property (
    adc_done |=> r.adc_chan != $past(r.adc_chan))
    else $error("channel not advanced after conversion");
  reverse_halt_a: assert property (
    r.halted |-> r.reverse)
    else $error("reverse low while halted");

  lock_seen_c: cover property ($rose(r.locked) ##[1:4] r.st == ST_SINE);
  relock_c: cover property (r.st == ST_STOP ##1 r.st == ST_SINE);
  conv_c: cover property (r.adc_start ##[1:50] adc_done);
endmodule : pmm_drive_ctrl

// ===== verif/pmm_motor_model.sv
`timescale 1ns/1ps
module pmm_motor_model (
  // clock
  input  wire logic     aclk,
  // rotation command
  input  wire logic     step,
  // sensor side
  output logic [2:0]    hall,
  // driver stage side
  input  pmm_pkg::gate_t gate,
  output logic          driven
);
  import pmm_pkg::*;

  // the rotor keeps its position through reset, so no reset here
  initial hall = 3'h1;

  // forward rotation, one sector per step
  always @(posedge aclk) begin
    if (step) begin
      case (hall)
        3'h1: hall <= 3'h5;
        3'h5: hall <= 3'h4;
        3'h4: hall <= 3'h6;
        3'h6: hall <= 3'h2;
        3'h2: hall <= 3'h3;
        default: hall <= 3'h1;
      endcase
    end
  end

  // any switch on means the bridge is energised
  assign driven = |{gate.hi, gate.lo};
endmodule : pmm_motor_model

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  import pmm_pkg::*;
  localparam logic [15:0] HALT_T = 16'h0004;
  localparam int          PER    = 510;
  logic        aclk;
  logic        aresetn;
  axi_req_t    axi_req;
  axi_rsp_t    axi_rsp;
  logic [2:0]  hall_in;
  logic        dir_in;
  gate_t       gate;
  logic        reverse_out;
  logic        tacho_out;
  logic        adc_start;
  logic        adc_chan;
  logic        adc_done = 1'b0;
  logic [7:0]  adc_data = 8'h00;
  logic        step;
  logic        driven;
  logic        exp_tacho;
  logic        last_chan = 1'b1;
  logic [31:0] rd_data;
  logic [1:0]  resp;
  int          pend;
  int          starts;
  int          base;
  int          miscompares;
  int          total_checks;

  pmm_drive_ctrl #(.PWM_DIV(8'h01), .HALT_TICKS(HALT_T), .LOCK_COUNT(4'h2)) dut (
    .aclk, .aresetn, .axi_req, .axi_rsp, .hall_in, .dir_in, .gate,
    .reverse_out, .tacho_out, .adc_start, .adc_chan, .adc_done, .adc_data);
  pmm_motor_model motor (.aclk, .step, .hall(hall_in), .gate, .driven);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    // one edge between calls, so no strobe is assigned twice in a step
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    axi_req.bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    chk(axi_rsp.bresp, RESP_OKAY, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
    rd_data = axi_rsp.rdata;
    resp    = axi_rsp.rresp;
  endtask : rd

  // status: halted, locked and state only
  task automatic chk_stat(input logic h, input logic l, input drive_state_t s);
    rd(OFS_STATUS);
    chk(rd_data & 32'h0f03, {20'h0, s, 6'h0, l, h}, "status");
  endtask : chk_stat

  task automatic hall_step();
    @(posedge aclk);
    step <= 1'b1;
    @(posedge aclk);
    step <= 1'b0;
    repeat (8) @(posedge aclk);
    exp_tacho = ~exp_tacho;
    chk(tacho_out, exp_tacho, "tacho");
    repeat (590) @(posedge aclk);
  endtask : hall_step

  // converter stand-in: answers three cycles after each start
  always @(posedge aclk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (pend == 1) begin
      adc_done <= 1'b1;
      adc_data <= adc_chan ? 8'h33 : 8'h5a;
    end
    if (pend > 0) pend--;
    if (adc_start) begin
      starts++;
      pend = 3;
      chk(adc_chan, !last_chan, "channel order");
      last_chan = adc_chan;
    end
  end

  initial begin
    #(20ns * 60000);
    miscompares++;
    end_of_test();
  end

  initial begin
    aresetn = 1'b0;
    axi_req = '0;
    dir_in = 1'b0;
    step = 1'b0;
    exp_tacho = 1'b0;
    repeat (5) @(posedge aclk);
    chk({gate, reverse_out, tacho_out}, 32'h2, "reset pins");
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_CTRL);
    chk(rd_data, {29'h0, CTRL_RST}, "ctrl reset");
    rd(OFS_GAINS);
    chk(rd_data, GAINS_RST, "gains reset");
    rd(8'h20);
    chk(resp, RESP_SLVERR, "unmapped");
    $display("test regs done");
    // no drive while neither locked nor halted
    repeat (PER * 2) @(posedge aclk);
    chk(driven, 1'b0, "idle drive");
    repeat (PER * 5) @(posedge aclk);
    chk_stat(1'b1, 1'b0, ST_BLOCK);
    chk(reverse_out, 1'b1, "halted reverse");
    rd(OFS_ADC);
    chk(rd_data, 32'h005a335a, "adc values");
    $display("test startup done");
    repeat (4) hall_step();
    chk_stat(1'b0, 1'b1, ST_SINE);
    chk(reverse_out, 1'b0, "fwd reverse");
    chk(driven, 1'b1, "sine drive");
    rd(OFS_SPEED);
    // hall steps 600 cycles apart see one or two ticks between them
    chk(rd_data[15:0] == INC_NUM || rd_data[15:0] == INC_NUM / 2, 1'b1, "increment");
    $display("test lock done");
    repeat (PER * 7) @(posedge aclk);
    chk_stat(1'b1, 1'b0, ST_BLOCK);
    $display("test halt done");
    repeat (3) hall_step();
    dir_in <= 1'b1;
    repeat (8) @(posedge aclk);
    chk_stat(1'b0, 1'b0, ST_STOP);
    chk(driven, 1'b0, "coast");
    dir_in <= 1'b0;
    repeat (3) hall_step();
    chk_stat(1'b0, 1'b1, ST_SINE);
    $display("test direction done");
    // braking variant of the stop, then relock on the restored direction
    wr(OFS_CTRL, 32'h6);
    dir_in <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(gate, {3'h0, 3'h7}, "brake");
    dir_in <= 1'b0;
    repeat (3) hall_step();
    chk_stat(1'b0, 1'b1, ST_SINE);
    $display("test brake done");
    // large setpoint gain: positive regulator output saturates the amplitude
    wr(OFS_GAINS, 32'hff000408);
    wr(OFS_CTRL, 32'h5);
    repeat (PER * 3) @(posedge aclk);
    rd(OFS_ADC);
    chk(rd_data, 32'h00ff335a, "closed loop amp");
    $display("test closed loop done");
    wr(OFS_CTRL, 32'h0);
    repeat (PER * 2) @(posedge aclk);
    base = starts;
    repeat (PER * 3) @(posedge aclk);
    chk(starts - base, 0, "stuck flag");
    rd(OFS_STATUS);
    chk(rd_data[STAT_OVF], 1'b1, "ovf flag");
    wr(OFS_STATUS, 32'h8);
    repeat (PER * 2) @(posedge aclk);
    chk(starts > base, 1'b1, "restart");
    wr(OFS_CTRL, {29'h0, CTRL_RST});
    $display("test overflow done");
    end_of_test();
  end
endmodule : tb
